// file: common/dau_pkg.sv
// constants for the dac update control block
package dau_pkg;
    localparam int WORD_BITS = 24;
    localparam int LONG_WORD_BITS = 32;
    localparam int CMD_WIDTH = 4;
    localparam int DATA_WIDTH = 16;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int DATA_MSB = 15;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] CMD_WRITE = 4'h0;
    localparam logic [3:0] CMD_UPDATE = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
    localparam logic [3:0] CMD_NOP = 4'hf;
    localparam logic [15:0] DAC_RESET_CODE = 16'h0000;
    localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;
endpackage : dau_pkg

// file: hdl/dau_control.sv
// update and power control of a single serial dac
// Notes on behaviour
// RULE1: select high, update low copies input register
// RULE2: update pulse during frame only powers up
// RULE3: update still low at load: execute, update
// RULE4: update low always powers up converter
// RULE5: update low at load blocks power-down
// RULE6: daisy chains need the 32-bit load
// RULE7: code msb first, trailing don't-care bits
// RULE8: one bit per rising shift clock
// RULE9: command, four spare bits, then data
// RULE10: command 0100 powers down, data ignored
// RULE11: command 1111 does nothing at all
// RULE12: pins synchronised, simultaneous events ordered
`timescale 1ns/10ps
module dau_control
    import dau_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic chip_select_load,
    input wire logic async_update_n,
    output logic serial_out,
    output logic [DATA_WIDTH-1:0] input_code,
    output logic [DATA_WIDTH-1:0] dac_code,
    output logic powered_up,
    output logic update_strobe
);
    logic sck_s;
    logic sdi_s;
    logic csl_s;
    logic upd_n_s;

    // RULE12: every pin through two flops
    dau_sync #(.RESET_VALUE(1'b0)) u_sync_sck
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(shift_clk),
        .sync_out(sck_s)
    );
    dau_sync #(.RESET_VALUE(1'b0)) u_sync_sdi
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(serial_in),
        .sync_out(sdi_s)
    );
    dau_sync #(.RESET_VALUE(1'b1)) u_sync_csl
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(chip_select_load),
        .sync_out(csl_s)
    );
    dau_sync #(.RESET_VALUE(1'b1)) u_sync_upd
    (
        .clk(clk),
        .rstn(rstn),
        .async_in(async_update_n),
        .sync_out(upd_n_s)
    );

    logic sck_d_reg;
    logic sck_d_next;
    logic csl_d_reg;
    logic csl_d_next;
    logic upd_d_reg;
    logic upd_d_next;
    logic [LONG_WORD_BITS-1:0] shift_reg;
    logic [LONG_WORD_BITS-1:0] shift_next;
    logic sdo_reg;
    logic sdo_next;
    logic [DATA_WIDTH-1:0] input_reg;
    logic [DATA_WIDTH-1:0] input_next;
    logic [DATA_WIDTH-1:0] dac_reg;
    logic [DATA_WIDTH-1:0] dac_next;
    logic power_reg;
    logic power_next;
    logic strobe_reg;
    logic strobe_next;

    logic sck_rise;
    logic sck_fall;
    logic csl_rise;
    logic upd_fall;
    logic [CMD_WIDTH-1:0] cmd;
    logic [DATA_WIDTH-1:0] word_data;

    assign sck_rise = sck_s & ~sck_d_reg;
    assign sck_fall = ~sck_s & sck_d_reg;
    assign csl_rise = csl_s & ~csl_d_reg;
    assign upd_fall = ~upd_n_s & upd_d_reg;
    // RULE9: command on top, data in the low half
    assign cmd = shift_reg[CMD_MSB:CMD_LSB];
    // RULE7: code left-aligned, padding bits kept as received
    assign word_data = shift_reg[DATA_MSB:0];

    always_comb
    begin
        sck_d_next = sck_s;
        csl_d_next = csl_s;
        upd_d_next = upd_n_s;
        shift_next = shift_reg;
        sdo_next = sdo_reg;
        input_next = input_reg;
        dac_next = dac_reg;
        power_next = power_reg;
        strobe_next = 1'b0;
        // RULE8: shift only inside the frame
        if (!csl_s && sck_rise)
        begin
            shift_next = {shift_reg[LONG_WORD_BITS-2:0], sdi_s};
        end
        // daisy output changes on the falling shift edge
        if (!csl_s && sck_fall)
        begin
            sdo_next = shift_reg[LONG_WORD_BITS-1];
        end
        // frame end wins the ordering when both land in one cycle
        if (csl_rise)
        begin
            case (cmd)
                CMD_WRITE:
                begin
                    input_next = word_data;
                end
                CMD_UPDATE:
                begin
                    dac_next = input_reg;
                    power_next = 1'b1;
                    strobe_next = 1'b1;
                end
                CMD_WRITE_UPDATE:
                begin
                    input_next = word_data;
                    dac_next = word_data;
                    power_next = 1'b1;
                    strobe_next = 1'b1;
                end
                // RULE10: power down, data dropped
                CMD_POWER_DOWN:
                begin
                    power_next = 1'b0;
                end
                // RULE11: nothing happens
                CMD_NOP:
                begin
                end
                default:
                begin
                end
            endcase
            // RULE3: held update after load also refreshes output
            if (!upd_n_s)
            begin
                if (cmd == CMD_WRITE)
                begin
                    dac_next = word_data;
                end
                else if (cmd != CMD_WRITE_UPDATE)
                begin
                    dac_next = input_reg;
                end
                strobe_next = 1'b1;
                // RULE5: power-down suppressed
                power_next = 1'b1;
            end
        end
        else if (upd_fall && csl_s)
        begin
            // RULE1: asynchronous update outside a frame
            dac_next = input_reg;
            power_next = 1'b1;
            strobe_next = 1'b1;
        end
        // RULE4: any update low wakes the converter
        // RULE2: inside a frame it touches only power
        if (upd_fall)
        begin
            power_next = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sck_d_reg <= 1'b0;
            csl_d_reg <= 1'b1;
            upd_d_reg <= 1'b1;
            shift_reg <= SHIFT_RESET;
            sdo_reg <= 1'b0;
            input_reg <= DAC_RESET_CODE;
            dac_reg <= DAC_RESET_CODE;
            power_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end
        else
        begin
            sck_d_reg <= sck_d_next;
            csl_d_reg <= csl_d_next;
            upd_d_reg <= upd_d_next;
            shift_reg <= shift_next;
            sdo_reg <= sdo_next;
            input_reg <= input_next;
            dac_reg <= dac_next;
            power_reg <= power_next;
            strobe_reg <= strobe_next;
        end
    end

    assign serial_out = sdo_reg;
    assign input_code = input_reg;
    assign dac_code = dac_reg;
    assign powered_up = power_reg;
    assign update_strobe = strobe_reg;
endmodule : dau_control

// file: hdl/dau_sync.sv
// two-flop synchroniser for one pin input
`timescale 1ns/10ps
module dau_sync
    import dau_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1_reg;
    logic stage1_next;
    logic stage2_reg;
    logic stage2_next;

    always_comb
    begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
        end
        else
        begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync_out = stage2_reg;
endmodule : dau_sync

// file: test/dau_assertions.sv
// port checker for the update control block
`timescale 1ns/10ps
module dau_checker
    import dau_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic chip_select_load,
    input wire logic async_update_n,
    input wire logic [DATA_WIDTH-1:0] input_code,
    input wire logic [DATA_WIDTH-1:0] dac_code,
    input wire logic powered_up,
    input wire logic update_strobe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // pins need up to 3 clk to take effect
    sequence s_fall_sel;
        $fell(async_update_n) && chip_select_load ##1 chip_select_load [*5];
    endsequence
    sequence s_held_low;
        !async_update_n [*6];
    endsequence
    a_strobe_single: assert property (update_strobe |=> !update_strobe)
        else $error("strobe too long");
    a_strobe_powers: assert property (update_strobe |=> powered_up)
        else $error("update left power off");
    a_async_copy: assert property (s_fall_sel |-> dac_code == input_code)
        else $error("async update missed");
    a_low_powers: assert property (s_held_low |-> powered_up)
        else $error("power off with update low");
    a_frame_hold: assert property ((!chip_select_load) [*6] |-> $stable(dac_code))
        else $error("dac moved in frame");
    a_strobe_match: assert property (update_strobe |-> dac_code == input_code)
        else $error("dac differs at strobe");
    a_dac_strobe: assert property ($changed(dac_code) |-> update_strobe)
        else $error("dac moved without strobe");
    a_input_load: assert property ($changed(input_code) |-> $past(chip_select_load, 2))
        else $error("input moved in frame");
endmodule : dau_checker
bind dau_control dau_checker i_chk (.clk(clk), .rstn(rstn),
    .chip_select_load(chip_select_load), .async_update_n(async_update_n),
    .input_code(input_code), .dac_code(dac_code), .powered_up(powered_up),
    .update_strobe(update_strobe));

// file: test/dau_control_test.sv
// self-checking bench for the update control block
`timescale 1ns/10ps
module dau_control_test
    import dau_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [DATA_WIDTH-1:0] input_code;
    logic [DATA_WIDTH-1:0] dac_code;
    logic powered_up;
    logic update_strobe;
    logic serial_out;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    initial forever #50 clk = ~clk;
    dau_host i_host (.clk(clk));
    dau_control i_dut (.clk(clk), .rstn(rstn), .shift_clk(i_host.shift_clk),
        .serial_in(i_host.serial_in), .chip_select_load(i_host.chip_select_load),
        .async_update_n(i_host.async_update_n), .serial_out(serial_out),
        .input_code(input_code),
        .dac_code(dac_code), .powered_up(powered_up), .update_strobe(update_strobe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] wd(input logic [3:0] c, input logic [15:0] d);
        return {8'h00, c, 4'h0, d};
    endfunction : wd
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // whole run is about 2300 clk
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end
    task automatic t_write();
        i_host.send(wd(CMD_WRITE_UPDATE, 16'ha5c3), 24, 0);
        check(dac_code, 16'ha5c3);
        i_host.send(wd(CMD_WRITE, 16'h3ff0), 32, 0);
        check(input_code, 16'h3ff0);
        check(dac_code, 16'ha5c3);
        i_host.pulse();
        check(dac_code, 16'h3ff0);
        $display("done t_write");
    endtask : t_write
    task automatic t_power();
        i_host.send(wd(CMD_POWER_DOWN, 16'h1234), 24, 0);
        check(16'(powered_up), 16'h0000);
        check(input_code, 16'h3ff0);
        // leading pad bit set so the daisy output shows the word's first bit
        i_host.send({8'h80, CMD_NOP, 4'h0, 16'h5555}, 32, 0);
        check(input_code, 16'h3ff0);
        check(16'(powered_up), 16'h0000);
        check(16'(serial_out), 16'h0001);
        i_host.send(wd(CMD_NOP, 16'h5555), 24, 1);
        check(16'(powered_up), 16'h0001);
        check(dac_code, 16'h3ff0);
        // bit 7 of the previous word, 32 rises back
        check(16'(serial_out), 16'h0000);
        $display("done t_power");
    endtask : t_power
    task automatic t_held();
        i_host.send(wd(CMD_POWER_DOWN, 16'h0000), 24, 0);
        i_host.send(wd(CMD_WRITE, 16'h0ab0), 24, 2);
        check(dac_code, 16'h0ab0);
        i_host.send(wd(CMD_POWER_DOWN, 16'h0000), 24, 2);
        check(16'(powered_up), 16'h0001);
        i_host.send(wd(CMD_POWER_DOWN, 16'h0000), 24, 0);
        check(16'(powered_up), 16'h0000);
        i_host.send(wd(CMD_WRITE, 16'h0c30), 24, 3);
        check(input_code, 16'h0c30);
        check(dac_code, 16'h0c30);
        check(16'(powered_up), 16'h0001);
        $display("done t_held");
    endtask : t_held
    initial
    begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        t_write();
        t_power();
        t_held();
        wrap_up();
    end
endmodule : dau_control_test

// file: test/dau_host.sv
// host model driving the serial port and update pin
`timescale 1ns/10ps
module dau_host
(
    input wire logic clk
);
    logic shift_clk = 1'b0;
    logic serial_in = 1'b0;
    logic chip_select_load = 1'b1;
    logic async_update_n = 1'b1;
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic send(input logic [31:0] w, input int n, input int mode);
        tick(1);
        chip_select_load = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in = w[i];
            async_update_n = !((mode == 1 && i == 12) || (mode == 2 && i <= 12));
            tick(4);
            shift_clk = 1'b1;
            tick(4);
            shift_clk = 1'b0;
        end
        tick(4);
        chip_select_load = 1'b1;
        // update falls with the load edge
        if (mode == 3)
            async_update_n = 1'b0;
        // line inverted, no stale bit
        serial_in = !serial_in;
        tick(8);
        async_update_n = 1'b1;
        tick(8);
    endtask : send
    task automatic pulse();
        tick(1);
        async_update_n = 1'b0;
        tick(8);
        async_update_n = 1'b1;
        tick(8);
    endtask : pulse
endmodule : dau_host
